// >>> design/ptw_consts.svh
// Constants for the PCI target memory-write block and its bus master.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PTW_CONSTS_SVH
`define PTW_CONSTS_SVH

// Core variant: 1 keeps the 64-bit extension, 0 builds a 32-bit core.
`define PTW_HAS_64 1'b1
// Bus command for a memory write.
`define PTW_CMD_MEM_WR 4'h7
// Base address ranges: six windows of 1 MiB each.
`define PTW_NUM_BAR 6
`define PTW_BAR_MASK 32'hFFF0_0000
`define PTW_BAR_BASE0 32'h8000_0000
`define PTW_BAR_STEP 32'h0010_0000
// Status vector layout.
`define PTW_TSR_HIT_HI 5
`define PTW_TSR_WIDE 7
`define PTW_TSR_BUSY 8
`define PTW_TSR_DONE 10
`define PTW_TSR_CLEAR 12'h000
// Dword select bit of the byte address in a 32-bit transfer.
`define PTW_ADDR_DW 2
// Cycles the master waits for a claim before giving up.
`define PTW_MABORT_CYC 4'h5
// Master register map, byte addresses.
`define PTW_REG_ADDR 5'h00
`define PTW_REG_DLO 5'h04
`define PTW_REG_DHI 5'h08
`define PTW_REG_CTRL 5'h0C
`define PTW_REG_STAT 5'h10
// Control and status fields.
`define PTW_CTRL_GO 0
`define PTW_CTRL_WIDE 1
`define PTW_CTRL_BE_LO 4
`define PTW_CTRL_BE_HI 11
`define PTW_STAT_BUSY 0
`define PTW_STAT_DONE 1
`define PTW_STAT_ABORT 2

`endif

// >>> design/ptw_pkg.sv
// Types shared by the target and the master of the write link.
// Assumes the constants header is compiled alongside.
package ptw_pkg;
    // Status vector towards the local side.
    typedef logic [11:0] ptw_tsr_t;
    // Target sequencer states.
    typedef enum logic [6:0] {
        TS_IDLE = 7'h01,
        TS_DECODE = 7'h02,
        TS_ARM = 7'h04,
        TS_CLAIM = 7'h08,
        TS_DATA = 7'h10,
        TS_TURN = 7'h20,
        TS_DRAIN = 7'h40
    } ptw_tstate_t;
    // Master sequencer states.
    typedef enum logic [3:0] {
        MS_IDLE = 4'h1,
        MS_ADDR = 4'h2,
        MS_DATA = 4'h4,
        MS_TURN = 4'h8
    } ptw_mstate_t;
endpackage

// >>> design/ptw_if.sv
// Shared PCI wires between the bus master and the write target.
// Assumes pull-ups on the control lines; released data lanes read zero.
`timescale 1ns/1ps
`default_nettype none
interface ptw_if;
    // Master drives, with enables.
    logic [63:0] ad_m;
    logic ad_oe_m;
    logic [7:0] cben_m;
    logic par_m;
    logic par64_m;
    logic par_oe_m;
    logic frame_n_m;
    logic irdy_n_m;
    logic req64_n_m;
    logic ctl_oe_m;
    // Target drives, with one enable for its control group.
    logic devsel_n_t;
    logic trdy_n_t;
    logic stop_n_t;
    logic ack64_n_t;
    logic ctl_oe_t;
    // Resolved wire levels.
    logic [63:0] ad;
    logic [7:0] cben;
    logic frame_n;
    logic irdy_n;
    logic req64_n;
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic ack64_n;

    // Undriven control lines float high through the pull-ups.
    assign ad = ad_oe_m ? ad_m : 64'h0;
    assign cben = ad_oe_m ? cben_m : 8'hFF;
    assign frame_n = ctl_oe_m ? frame_n_m : 1'b1;
    assign irdy_n = ctl_oe_m ? irdy_n_m : 1'b1;
    assign req64_n = ctl_oe_m ? req64_n_m : 1'b1;
    assign devsel_n = ctl_oe_t ? devsel_n_t : 1'b1;
    assign trdy_n = ctl_oe_t ? trdy_n_t : 1'b1;
    assign stop_n = ctl_oe_t ? stop_n_t : 1'b1;
    assign ack64_n = ctl_oe_t ? ack64_n_t : 1'b1;

    modport dev (
        input ad, cben, frame_n, irdy_n, req64_n,
        output devsel_n_t, trdy_n_t, stop_n_t, ack64_n_t, ctl_oe_t
    );
    modport mst (
        input devsel_n, trdy_n, stop_n, ack64_n,
        output ad_m, ad_oe_m, cben_m, par_m, par64_m, par_oe_m,
        output frame_n_m, irdy_n_m, req64_n_m, ctl_oe_m
    );
endinterface
`default_nettype wire

// >>> design/ptw_master.sv
// Bus master end: runs one memory write on the PCI wires per order.
// Assumes software orders it over Avalon-MM; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ptw_consts.svh"
module ptw_master (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // PCI wires.
    ptw_if.mst PCI_BUS,
    // Avalon-MM slave.
    input wire logic [4:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT
);
    import ptw_pkg::*;

    ptw_mstate_t state_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [31:0] addr_ff;
    logic [31:0] dlo_ff;
    logic [31:0] dhi_ff;
    logic wide_ff;
    logic [7:0] be_n_ff;
    logic go_ff;
    logic done_ff;
    logic abort_ff;
    logic [3:0] cnt_ff;
    logic [63:0] ad_ff;
    logic [7:0] cben_ff;
    logic ad_oe_ff;
    logic ctl_oe_ff;
    logic frame_n_ff;
    logic irdy_n_ff;
    logic req64_n_ff;
    logic par_ff;
    logic par64_ff;
    logic par_oe_ff;
    logic req;
    logic acc;
    logic fin;
    logic give_up;

    // A request is taken on the edge where waitrequest is already low.
    assign req = AVS_READ_IN | AVS_WRITE_IN;
    assign acc = req & ~wait_ff;
    assign fin = (state_ff == MS_DATA) & ~PCI_BUS.trdy_n & ~irdy_n_ff;
    assign give_up = (state_ff == MS_DATA) & PCI_BUS.devsel_n &
                     (cnt_ff == `PTW_MABORT_CYC);

    // Register read decode.
    function automatic logic [31:0] rd_mux(input logic [4:0] a);
        case (a)
            `PTW_REG_ADDR: rd_mux = addr_ff;
            `PTW_REG_DLO: rd_mux = dlo_ff;
            `PTW_REG_DHI: rd_mux = dhi_ff;
            `PTW_REG_CTRL: rd_mux = {20'h0, be_n_ff, 2'h0, wide_ff, 1'b0};
            `PTW_REG_STAT: rd_mux = {29'h0, abort_ff, done_ff,
                                     state_ff != MS_IDLE};
            default: rd_mux = 32'h0;
        endcase
    endfunction

    // One wait cycle per access; read data captured while waiting.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (req & wait_ff) begin
                rdata_ff <= rd_mux(AVS_ADDRESS_IN);
            end
        end
    end

    // Order registers; the go bit yields one pulse while idle.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            addr_ff <= 32'h0;
            dlo_ff <= 32'h0;
            dhi_ff <= 32'h0;
            wide_ff <= 1'b0;
            be_n_ff <= 8'h00;
            go_ff <= 1'b0;
        end else begin
            go_ff <= 1'b0;
            if (acc & AVS_WRITE_IN) begin
                case (AVS_ADDRESS_IN)
                    `PTW_REG_ADDR: addr_ff <= AVS_WRITEDATA_IN;
                    `PTW_REG_DLO: dlo_ff <= AVS_WRITEDATA_IN;
                    `PTW_REG_DHI: dhi_ff <= AVS_WRITEDATA_IN;
                    `PTW_REG_CTRL: begin
                        wide_ff <= AVS_WRITEDATA_IN[`PTW_CTRL_WIDE];
                        be_n_ff <= AVS_WRITEDATA_IN[`PTW_CTRL_BE_HI:
                                                    `PTW_CTRL_BE_LO];
                        go_ff <= AVS_WRITEDATA_IN[`PTW_CTRL_GO] &
                                 (state_ff == MS_IDLE);
                    end
                    default: ;
                endcase
            end
        end
    end

    // Sticky done and abort flags; a new event wins over the clear.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            done_ff <= (fin | give_up) | (done_ff & ~(acc & AVS_WRITE_IN &
                (AVS_ADDRESS_IN == `PTW_REG_STAT) &
                AVS_WRITEDATA_IN[`PTW_STAT_DONE]));
            abort_ff <= give_up | (abort_ff & ~(acc & AVS_WRITE_IN &
                (AVS_ADDRESS_IN == `PTW_REG_STAT) &
                AVS_WRITEDATA_IN[`PTW_STAT_ABORT]));
        end
    end

    // Address phase, then a single data phase, then release.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_ff <= MS_IDLE;
            cnt_ff <= 4'h0;
            ad_ff <= 64'h0;
            cben_ff <= 8'hFF;
            ad_oe_ff <= 1'b0;
            ctl_oe_ff <= 1'b0;
            frame_n_ff <= 1'b1;
            irdy_n_ff <= 1'b1;
            req64_n_ff <= 1'b1;
        end else begin
            case (state_ff)
                MS_IDLE: begin
                    ctl_oe_ff <= 1'b0;
                    if (go_ff) begin
                        state_ff <= MS_ADDR;
                        ctl_oe_ff <= 1'b1;
                        ad_oe_ff <= 1'b1;
                        frame_n_ff <= 1'b0;
                        req64_n_ff <= ~(wide_ff & `PTW_HAS_64);
                        ad_ff <= {32'h0, addr_ff};
                        cben_ff <= {4'hF, `PTW_CMD_MEM_WR};
                    end
                end
                MS_ADDR: begin
                    state_ff <= MS_DATA;
                    frame_n_ff <= 1'b1;
                    req64_n_ff <= 1'b1;
                    irdy_n_ff <= 1'b0;
                    ad_ff <= {dhi_ff, dlo_ff};
                    cben_ff <= be_n_ff;
                    cnt_ff <= 4'h0;
                end
                MS_DATA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (fin | give_up) begin
                        state_ff <= MS_TURN;
                        irdy_n_ff <= 1'b1;
                        ad_oe_ff <= 1'b0;
                    end
                end
                MS_TURN: begin
                    state_ff <= MS_IDLE;
                    ctl_oe_ff <= 1'b0;
                end
                default: state_ff <= MS_IDLE;
            endcase
        end
    end

    // Parity follows the lanes it covers by one cycle.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            par_ff <= 1'b0;
            par64_ff <= 1'b0;
            par_oe_ff <= 1'b0;
        end else begin
            par_ff <= ^{ad_ff[31:0], cben_ff[3:0]};
            par64_ff <= ^{ad_ff[63:32], cben_ff[7:4]};
            par_oe_ff <= ad_oe_ff;
        end
    end

    assign AVS_READDATA_OUT = rdata_ff;
    assign AVS_WAITREQUEST_OUT = wait_ff;
    assign PCI_BUS.ad_m = ad_ff;
    assign PCI_BUS.ad_oe_m = ad_oe_ff;
    assign PCI_BUS.cben_m = cben_ff;
    assign PCI_BUS.par_m = par_ff;
    assign PCI_BUS.par64_m = par64_ff;
    assign PCI_BUS.par_oe_m = par_oe_ff;
    assign PCI_BUS.frame_n_m = frame_n_ff;
    assign PCI_BUS.irdy_n_m = irdy_n_ff;
    assign PCI_BUS.req64_n_m = req64_n_ff;
    assign PCI_BUS.ctl_oe_m = ctl_oe_ff;
endmodule
`default_nettype wire

// >>> design/ptw_target.sv
// PCI target end for memory writes, with its local-side handshake.
// Assumes PCI wires through the shared interface and one PCI clock.
//
// How it works
// - Accept single and mismatched-width memory writes.
// - 32-bit variant ignores all 64-bit extension signals.
// - Master asserts frame, address and command together.
// - Asserted req64 during address requests 64 bits.
// - Latch address, command; decode against every window.
// - Turn on target drivers the cycle after decode.
// - Assert devsel, ack64 one cycle after drivers.
// - Single phase: master drops frame, raises irdy.
// - Report claim: local frame plus window hit bit.
// - Present latched command and address with hit.
// - Status bit 7 flags a 64-bit transfer.
// - Status bit 8 flags busy PCI side.
// - Local ready means data acceptable next cycle.
// - Hold off trdy until local ready seen.
// - Assert trdy to take the data phase.
// - Register data, byte enables; acknowledge and transfer locally.
// - Status bit 10 after transfer; clear next cycle.
// - Drive controls high one cycle, then release.
// - Drop local frame when pipeline is empty.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ptw_consts.svh"
module ptw_target (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // PCI wires.
    ptw_if.dev PCI_BUS,
    // Local-side handshake.
    input wire logic LOCAL_READY_N_IN,
    output logic LOCAL_TXN_FRAME_N_OUT,
    output ptw_pkg::ptw_tsr_t TARGET_STATUS_VECTOR_OUT,
    output logic LOCAL_ACKNOWLEDGE_N_OUT,
    output logic LOCAL_TRANSFER_N_OUT,
    // Local-side command, address and data.
    output logic [3:0] LOCAL_CMD_OUT,
    output logic [31:0] LOCAL_ADDR_OUT,
    output logic [63:0] LOCAL_DATA_OUT,
    output logic [7:0] LOCAL_BE_N_OUT
);
    import ptw_pkg::*;

    ptw_tstate_t state_ff;
    ptw_tstate_t nxt_state;
    logic bus_idle_ff;
    logic [31:0] addr_ff;
    logic [3:0] cmd_ff;
    logic wide_ff;
    logic [5:0] hit_w;
    logic claim;
    logic ctl_oe_ff;
    logic devsel_n_ff;
    logic trdy_n_ff;
    logic stop_n_ff;
    logic ack64_n_ff;
    logic lframe_n_ff;
    ptw_tsr_t tsr_ff;
    logic [3:0] lcmd_ff;
    logic [31:0] ladr_ff;
    logic [63:0] ldat_ff;
    logic [7:0] lbe_n_ff;
    logic lack_n_ff;
    logic lxfr_n_ff;
    logic addr_phase;
    logic data_done;

    // Tests one address against one base window.
    function automatic logic in_window(input logic [31:0] a,
                                       input logic [31:0] base);
        in_window = (a & `PTW_BAR_MASK) == base;
    endfunction

    // One comparator per base window.
    genvar gi;
    generate
        for (gi = 0; gi < `PTW_NUM_BAR; gi = gi + 1) begin : g_bar
            localparam logic [31:0] BASE =
                `PTW_BAR_BASE0 + 32'(gi) * `PTW_BAR_STEP;
            assign hit_w[gi] = in_window(addr_ff, BASE);
        end
    endgenerate

    // Claim only a memory write that lands inside a window.
    assign claim = (|hit_w) & (cmd_ff == `PTW_CMD_MEM_WR);
    // An address phase is frame falling on an idle bus.
    assign addr_phase = bus_idle_ff & ~PCI_BUS.frame_n & PCI_BUS.irdy_n;
    // The data phase completes when both ready lines are low.
    assign data_done = ~PCI_BUS.irdy_n & ~trdy_n_ff;

    // Tracks whether the bus was idle on the previous edge.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            bus_idle_ff <= 1'b1;
        end else begin
            bus_idle_ff <= PCI_BUS.frame_n & PCI_BUS.irdy_n;
        end
    end

    // Sequencer next state.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TS_IDLE: begin
                if (addr_phase) begin
                    nxt_state = TS_DECODE;
                end
            end
            TS_DECODE: nxt_state = claim ? TS_ARM : TS_IDLE;
            TS_ARM: nxt_state = TS_CLAIM;
            TS_CLAIM: begin
                if (!LOCAL_READY_N_IN) begin
                    nxt_state = TS_DATA;
                end
            end
            TS_DATA: begin
                if (data_done) begin
                    nxt_state = TS_TURN;
                end
            end
            TS_TURN: nxt_state = TS_DRAIN;
            TS_DRAIN: nxt_state = TS_IDLE;
            default: nxt_state = TS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_ff <= TS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Address, command and width captured in the address phase.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            addr_ff <= 32'h0;
            cmd_ff <= 4'h0;
            wide_ff <= 1'b0;
        end else begin
            if (state_ff == TS_IDLE && addr_phase) begin
                addr_ff <= PCI_BUS.ad[31:0];
                cmd_ff <= PCI_BUS.cben[3:0];
                wide_ff <= ~PCI_BUS.req64_n & `PTW_HAS_64;
            end
        end
    end

    // PCI control drivers: enable, claim, ready, end and release.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ctl_oe_ff <= 1'b0;
            devsel_n_ff <= 1'b1;
            trdy_n_ff <= 1'b1;
            stop_n_ff <= 1'b1;
            ack64_n_ff <= 1'b1;
        end else begin
            case (nxt_state)
                TS_ARM: begin
                    ctl_oe_ff <= 1'b1;
                    devsel_n_ff <= 1'b1;
                    trdy_n_ff <= 1'b1;
                    stop_n_ff <= 1'b1;
                    ack64_n_ff <= 1'b1;
                end
                TS_CLAIM: begin
                    devsel_n_ff <= 1'b0;
                    ack64_n_ff <= ~wide_ff;
                end
                TS_DATA: trdy_n_ff <= 1'b0;
                TS_TURN: begin
                    devsel_n_ff <= 1'b1;
                    trdy_n_ff <= 1'b1;
                    stop_n_ff <= 1'b1;
                    ack64_n_ff <= 1'b1;
                end
                default: ctl_oe_ff <= 1'b0;
            endcase
        end
    end

    // Local frame from claim until the pipeline has drained.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            lframe_n_ff <= 1'b1;
        end else if (nxt_state == TS_ARM) begin
            lframe_n_ff <= 1'b0;
        end else if (state_ff == TS_DRAIN) begin
            lframe_n_ff <= 1'b1;
        end
    end

    // Status vector: hit, width and busy, then done, then cleared.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            tsr_ff <= `PTW_TSR_CLEAR;
        end else begin
            case (nxt_state)
                TS_ARM: begin
                    tsr_ff <= `PTW_TSR_CLEAR;
                    tsr_ff[`PTW_TSR_HIT_HI:0] <= hit_w;
                    tsr_ff[`PTW_TSR_WIDE] <= wide_ff;
                    tsr_ff[`PTW_TSR_BUSY] <= 1'b1;
                end
                TS_TURN: tsr_ff[`PTW_TSR_DONE] <= 1'b1;
                TS_DRAIN: tsr_ff <= `PTW_TSR_CLEAR;
                default: ;
            endcase
        end
    end

    // Command and address shown to the local side with the hit.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            lcmd_ff <= 4'h0;
            ladr_ff <= 32'h0;
        end else if (nxt_state == TS_ARM) begin
            lcmd_ff <= cmd_ff;
            ladr_ff <= addr_ff;
        end
    end

    // Write data registered one cycle after the data phase.
    // A 32-bit write lands in the dword lane its address selects.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ldat_ff <= 64'h0;
            lbe_n_ff <= 8'hFF;
            lack_n_ff <= 1'b1;
            lxfr_n_ff <= 1'b1;
        end else if (state_ff == TS_DATA && data_done) begin
            lack_n_ff <= 1'b0;
            lxfr_n_ff <= LOCAL_READY_N_IN;
            if (wide_ff) begin
                ldat_ff <= PCI_BUS.ad;
                lbe_n_ff <= PCI_BUS.cben;
            end else if (addr_ff[`PTW_ADDR_DW]) begin
                ldat_ff <= {PCI_BUS.ad[31:0], 32'h0};
                lbe_n_ff <= {PCI_BUS.cben[3:0], 4'hF};
            end else begin
                ldat_ff <= {32'h0, PCI_BUS.ad[31:0]};
                lbe_n_ff <= {4'hF, PCI_BUS.cben[3:0]};
            end
        end else begin
            lack_n_ff <= 1'b1;
            lxfr_n_ff <= 1'b1;
        end
    end

    assign PCI_BUS.ctl_oe_t = ctl_oe_ff;
    assign PCI_BUS.devsel_n_t = devsel_n_ff;
    assign PCI_BUS.trdy_n_t = trdy_n_ff;
    assign PCI_BUS.stop_n_t = stop_n_ff;
    assign PCI_BUS.ack64_n_t = ack64_n_ff;
    assign LOCAL_TXN_FRAME_N_OUT = lframe_n_ff;
    assign TARGET_STATUS_VECTOR_OUT = tsr_ff;
    assign LOCAL_ACKNOWLEDGE_N_OUT = lack_n_ff;
    assign LOCAL_TRANSFER_N_OUT = lxfr_n_ff;
    assign LOCAL_CMD_OUT = lcmd_ff;
    assign LOCAL_ADDR_OUT = ladr_ff;
    assign LOCAL_DATA_OUT = ldat_ff;
    assign LOCAL_BE_N_OUT = lbe_n_ff;
endmodule
`default_nettype wire

// >>> sim/ptw_properties.sv
// Concurrent checks on the wires between the write master and target.
// Assumes one clock, an async low reset and pull-ups on control lines.
`timescale 1ns/1ps
`default_nettype none
`include "ptw_consts.svh"
module ptw_properties (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // Master side of the wires.
    input wire logic [63:0] ad,
    input wire logic [7:0] cben,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic req64_n,
    // Target drives and resolved levels.
    input wire logic devsel_n_t,
    input wire logic trdy_n_t,
    input wire logic stop_n_t,
    input wire logic ack64_n_t,
    input wire logic ctl_oe_t,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic ack64_n
);
    logic hit;
    // A memory write whose address falls in one of the six windows.
    assign hit = cben[3:0] == `PTW_CMD_MEM_WR && ad[31:20] - 12'h800 < 12'h006;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // Address phase: idle edge, then frame low while irdy is still high.
    sequence s_addr;
        frame_n && irdy_n ##1 !frame_n && irdy_n;
    endsequence
    sequence s_wide;
        s_addr ##0 hit && !req64_n;
    endsequence
    sequence s_narrow;
        s_addr ##0 hit && req64_n;
    endsequence
    drv_on_a: assert property (
        s_addr ##0 hit |-> ##1 !ctl_oe_t ##1 ctl_oe_t && devsel_n)
        else $error("drivers not enabled after decode");
    claim_wide_a: assert property (
        s_wide |-> ##3 !devsel_n && !ack64_n)
        else $error("wide claim missing");
    claim_narrow_a: assert property (
        s_narrow |-> ##3 !devsel_n && ack64_n)
        else $error("narrow claim wrong");
    no_hit_a: assert property (
        s_addr ##0 !hit |-> ##1 !ctl_oe_t [*6])
        else $error("target drove on a miss");
    devsel_hold_a: assert property (
        !devsel_n && trdy_n |=> !devsel_n)
        else $error("devsel dropped before data");
    trdy_gate_a: assert property (
        !trdy_n |-> !devsel_n && !$past(devsel_n))
        else $error("trdy without claim");
    data_end_a: assert property (
        !trdy_n && !irdy_n |=> ctl_oe_t && devsel_n_t && trdy_n_t
        && stop_n_t && ack64_n_t ##1 !ctl_oe_t)
        else $error("controls not parked high then released");
    stop_idle_a: assert property (
        ctl_oe_t |-> stop_n_t)
        else $error("stop asserted");
endmodule
`default_nettype wire

// >>> sim/pci_target_memory_write_bench.sv
// Bench joining the write master and target face to face.
// Assumes the design files and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ptw_consts.svh"
module pci_target_memory_write_bench;
    import ptw_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic rdy_n = 1'b1;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, ladr, a, dlo, dhi, st;
    logic wait_rq, frm_n, ack_n, xfr_n, wide;
    logic [3:0] cmd;
    logic [63:0] ldat;
    logic [7:0] lbe, be;
    ptw_tsr_t tsr, xt;
    integer seed = 32'h8ce3;
    integer n_errors = 0;
    integer n_compared = 0;
    integer k, w, dly, j;
    ptw_if bus_i ();
    ptw_master ptw_master_i (.CLK_IN(clk_in), .RSTN_IN(rstn_in),
        .PCI_BUS(bus_i.mst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wait_rq));
    ptw_target ptw_target_i (.CLK_IN(clk_in), .RSTN_IN(rstn_in),
        .PCI_BUS(bus_i.dev), .LOCAL_READY_N_IN(rdy_n),
        .LOCAL_TXN_FRAME_N_OUT(frm_n), .TARGET_STATUS_VECTOR_OUT(tsr),
        .LOCAL_ACKNOWLEDGE_N_OUT(ack_n), .LOCAL_TRANSFER_N_OUT(xfr_n),
        .LOCAL_CMD_OUT(cmd), .LOCAL_ADDR_OUT(ladr),
        .LOCAL_DATA_OUT(ldat), .LOCAL_BE_N_OUT(lbe));
    ptw_properties ptw_properties_i (.CLK_IN(clk_in), .RSTN_IN(rstn_in),
        .ad(bus_i.ad), .cben(bus_i.cben), .frame_n(bus_i.frame_n),
        .irdy_n(bus_i.irdy_n), .req64_n(bus_i.req64_n),
        .devsel_n_t(bus_i.devsel_n_t), .trdy_n_t(bus_i.trdy_n_t),
        .stop_n_t(bus_i.stop_n_t), .ack64_n_t(bus_i.ack64_n_t),
        .ctl_oe_t(bus_i.ctl_oe_t), .devsel_n(bus_i.devsel_n),
        .trdy_n(bus_i.trdy_n), .ack64_n(bus_i.ack64_n));
    // Free-running clock of 100 ns period.
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // A wait that ran out counts as a mismatch and ends the run.
    task automatic fail_wait;
        n_errors++;
        $display("unexpected at %0t: wait timed out", $time);
        end_sim;
    endtask
    // One Avalon access, held until waitrequest is seen low at an edge.
    task automatic avs(input logic w_en, input logic [4:0] ad,
        input logic [31:0] d);
        integer i;
        @(posedge clk_in);
        adr <= ad;
        wr <= w_en;
        rd <= !w_en;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (wait_rq !== 1'b0 && i < 30);
        if (i >= 30) begin
            fail_wait;
        end
        st = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Bounded wait until local frame, acknowledge or master busy is low.
    task automatic wait_lo(input integer s);
        integer i;
        i = 0;
        do begin
            if (s == 2) begin
                avs(1'b0, `PTW_REG_STAT, 32'h0);
            end else begin
                @(posedge clk_in);
            end
            i++;
        end while ((s == 0 ? frm_n : s == 1 ? ack_n : st[0]) !== 1'b0
            && i < 30);
        if (i >= 30) begin
            fail_wait;
        end
    endtask
    // Expected local byte enables and data of one completed write.
    function automatic logic [71:0] exp_lane(input logic wd,
        input logic [31:0] ad, input logic [31:0] lo,
        input logic [31:0] hi, input logic [7:0] b);
        if (wd) begin
            return {b, hi, lo};
        end
        if (ad[`PTW_ADDR_DW]) begin
            return {b[3:0], 4'hF, lo, 32'h0};
        end
        return {4'hF, b[3:0], 32'h0, lo};
    endfunction
    // Reset, then random writes over every window and two missing ones.
    initial begin
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        avs(1'b0, 5'h14, 32'h0);
        chk(st, 32'h0);
        for (k = 0; k < 16; k++) begin
            w = k < 8 ? k : $unsigned($random(seed)) % 8;
            dly = k < 2 ? k * 3 : $unsigned($random(seed)) % 4;
            wide = 1'($random(seed));
            a = `PTW_BAR_BASE0 + w * `PTW_BAR_STEP
                + ($random(seed) & 32'h000F_FFFC);
            dlo = $random(seed);
            dhi = $random(seed);
            be = k == 0 ? 8'h00 : 8'($random(seed));
            avs(1'b1, `PTW_REG_ADDR, a);
            avs(1'b1, `PTW_REG_DLO, dlo);
            avs(1'b1, `PTW_REG_DHI, dhi);
            avs(1'b1, `PTW_REG_CTRL, {20'h0, be, 2'b00, wide, 1'b1});
            if (w < `PTW_NUM_BAR) begin
                wait_lo(0);
                xt = 12'h100 | (12'(wide) << 7) | (12'h1 << w);
                chk(tsr, xt);
                chk({cmd, ladr}, {`PTW_CMD_MEM_WR, a});
                for (j = 0; j <= dly; j++) begin
                    if (j == dly) begin
                        rdy_n <= 1'b0;
                    end
                    @(posedge clk_in);
                    chk(bus_i.trdy_n, 1'b1);
                end
                rdy_n <= 1'(k); // Odd tests withdraw ready at the data edge.
                wait_lo(1);
                chk({lbe, ldat}, exp_lane(wide, a, dlo, dhi, be));
                chk({xfr_n, tsr}, {1'(k), xt | 12'h400});
                rdy_n <= 1'b1;
                @(posedge clk_in);
                chk({ack_n, tsr}, {1'b1, 12'h000});
                @(posedge clk_in);
                chk(frm_n, 1'b1);
            end else begin
                repeat (10) begin
                    @(posedge clk_in);
                    chk({frm_n, ack_n, tsr}, {2'b11, 12'h000});
                end
            end
            wait_lo(2);
            chk(st[2:1], w < `PTW_NUM_BAR ? 2'b01 : 2'b11);
            avs(1'b1, `PTW_REG_STAT, 32'h6);
            $display("test %0d done", k);
        end
        end_sim;
    end
endmodule
`default_nettype wire
